// ### rtl/flash_status_pkg.sv
// constants and types shared by the status register logic
package flash_status_pkg;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] OP_WRITE_STATUS2 = 8'h31;
  localparam logic [7:0] OP_READ_STATUS   = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_SOFT_RESET    = 8'hF0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BUSY_POS       = 0;
  localparam int WEL_POS        = 1;
  localparam int PROTECT_POS    = 2;
  localparam int GUARD_PIN_POS  = 4;
  localparam int LOCK_POS       = 7;
  localparam int PERMIT_POS     = 4;

  // ---------------------------------------------------------------
  // counts and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] LAST_BIT       = 3'h7;
  localparam logic [1:0] BYTES_OPCODE   = 2'h1;
  localparam logic [1:0] BYTES_WITH_DATA = 2'h2;
  localparam logic [1:0] BYTES_MAX      = 2'h3;
  localparam logic [7:0] STATUS2_RESET  = 8'h00;
  localparam int         SYNC_STAGES    = 2;

  // serial pins as seen by the block
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic guard_n;
  } link_pins_t;

  // command decode states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_OPCODE = 2'b01,
    ST_DATA   = 2'b10,
    ST_READ   = 2'b11
  } cmd_state_t;

endpackage : flash_status_pkg

// ### rtl/pin_sync.sv
// two-stage synchroniser for the serial link pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire flash_status_pkg::link_pins_t pins_in,
  output var  flash_status_pkg::link_pins_t pins_out
);
  import flash_status_pkg::*;

  localparam int W = $bits(link_pins_t);
  localparam logic [W-1:0] IDLE_LEVEL = 4'hD; // sck 1, cs_n 1, si 0, guard 1

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1_reg[i] <= IDLE_LEVEL[i];
          stage2_reg[i] <= IDLE_LEVEL[i];
        end else begin
          stage1_reg[i] <= pins_in[i];
          stage2_reg[i] <= stage1_reg[i];
        end
      end
    end
  endgenerate

  assign pins_out = stage2_reg;

endmodule : pin_sync
`default_nettype wire

// ### rtl/flash_status_regs.sv
// status bytes, write latch and status write commands of the serial flash
`timescale 1ns/10ps
`default_nettype none
module flash_status_regs (
  input  wire logic CLOCK,
  input  wire logic RST_N,
  input  wire logic SCK,
  input  wire logic CS_N,
  input  wire logic SI,
  input  wire logic GUARD_N,
  input  wire logic OP_BUSY,
  output logic      SO,
  output logic      SO_OE,
  output logic      SOFT_RESET,
  output logic      ARRAY_PROTECTED,
  output logic      WRITE_LATCH,
  output logic      PROTECT_LOCK,
  output logic      RESET_PERMIT
);
  import flash_status_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisation and edge detection
  // ---------------------------------------------------------------
  link_pins_t pins_raw;
  link_pins_t pins_sync;
  logic       sck_prev_reg;
  logic       cs_prev_reg;

  assign pins_raw = '{sck: SCK, cs_n: CS_N, si: SI, guard_n: GUARD_N};

  pin_sync u_sync (
    .clk      (CLOCK),
    .rst_n    (RST_N),
    .pins_in  (pins_raw),
    .pins_out (pins_sync)
  );

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sck_prev_reg <= 1'b1;
      cs_prev_reg  <= 1'b1;
    end else begin
      sck_prev_reg <= pins_sync.sck;
      cs_prev_reg  <= pins_sync.cs_n;
    end
  end

  logic selected;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  assign selected = !pins_sync.cs_n;
  assign sck_rise = selected && pins_sync.sck && !sck_prev_reg;
  assign sck_fall = selected && !pins_sync.sck && sck_prev_reg;
  assign cs_fall  = !pins_sync.cs_n && cs_prev_reg;
  assign cs_rise  = pins_sync.cs_n && !cs_prev_reg;

  // ---------------------------------------------------------------
  // serial shifter and byte counting
  // ---------------------------------------------------------------
  logic [2:0] bit_reg;
  logic [1:0] bytes_reg;
  logic [7:0] shift_reg;
  logic [7:0] opcode_reg;
  logic [7:0] data_reg;
  logic [7:0] shift_next;

  assign shift_next = {shift_reg[6:0], pins_sync.si};

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      bit_reg   <= '0;
      bytes_reg <= '0;
      shift_reg <= '0;
    end else if (cs_fall) begin
      bit_reg   <= '0;
      bytes_reg <= '0;
      shift_reg <= '0;
    end else if (sck_rise) begin
      shift_reg <= shift_next;
      bit_reg   <= bit_reg + 3'h1;
      if (bit_reg == LAST_BIT && bytes_reg != BYTES_MAX) begin
        bytes_reg <= bytes_reg + 2'h1;
      end
    end
  end

  // only the first two bytes are kept; later bytes are dropped
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      opcode_reg <= '0;
      data_reg   <= '0;
    end else if (cs_fall) begin
      opcode_reg <= '0;
      data_reg   <= '0;
    end else if (sck_rise && bit_reg == LAST_BIT) begin
      if (bytes_reg == '0) begin
        opcode_reg <= shift_next;
      end
      if (bytes_reg == BYTES_OPCODE) begin
        data_reg <= shift_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // command state
  // ---------------------------------------------------------------
  cmd_state_t state_reg;
  logic       opcode_done;

  assign opcode_done = bytes_reg != '0;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
    end else if (cs_fall) begin
      state_reg <= ST_OPCODE;
    end else if (cs_rise) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_OPCODE: begin
          if (sck_rise && bit_reg == LAST_BIT) begin
            state_reg <= (shift_next == OP_READ_STATUS) ? ST_READ : ST_DATA;
          end
        end
        ST_DATA:  state_reg <= ST_DATA;
        ST_READ:  state_reg <= ST_READ;
        ST_IDLE:  state_reg <= ST_IDLE;
        default:  state_reg <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // deselect evaluation
  // ---------------------------------------------------------------
  logic lock_reg;
  logic protect_reg;
  logic permit_reg;
  logic wel_reg;
  logic guard_on;
  logic on_boundary;
  logic data_done;
  logic is_wsr1;
  logic is_wsr2;
  logic new_lock;
  logic clear_blocked;

  assign guard_on      = !pins_sync.guard_n;
  assign on_boundary   = bit_reg == '0;
  assign data_done     = bytes_reg >= BYTES_WITH_DATA;
  assign is_wsr1       = cs_rise && opcode_done && opcode_reg == OP_WRITE_STATUS;
  assign is_wsr2       = cs_rise && opcode_done
                         && opcode_reg == OP_WRITE_STATUS2;
  assign new_lock      = data_reg[LOCK_POS];
  assign clear_blocked = guard_on && lock_reg && !new_lock;

  // protection lock and array protect
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      lock_reg    <= 1'b0;
      protect_reg <= 1'b0;
    end else if (is_wsr1 && wel_reg && data_done && on_boundary
                 && !OP_BUSY && !clear_blocked) begin
      lock_reg <= new_lock;
      if (!(guard_on && lock_reg)) begin
        protect_reg <= data_reg[PROTECT_POS];
      end
    end
  end

  // reset permit: only the byte-two write touches it
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      permit_reg <= STATUS2_RESET[PERMIT_POS];
    end else if (is_wsr2 && wel_reg && data_done && on_boundary
                 && !OP_BUSY) begin
      permit_reg <= data_reg[PERMIT_POS];
    end
  end

  // write latch
  logic full_single;

  assign full_single = cs_rise && bytes_reg == BYTES_OPCODE && on_boundary;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wel_reg <= 1'b0;
    end else if (is_wsr1 || is_wsr2) begin
      wel_reg <= 1'b0;
    end else if (full_single && opcode_reg == OP_WRITE_DISABLE) begin
      wel_reg <= 1'b0;
    end else if (full_single && opcode_reg == OP_SOFT_RESET
                 && permit_reg) begin
      wel_reg <= 1'b0;
    end else if (full_single && opcode_reg == OP_WRITE_ENABLE
                 && !OP_BUSY) begin
      wel_reg <= 1'b1;
    end
  end

  // soft reset pulse, permitted only by the permit bit
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      SOFT_RESET <= 1'b0;
    end else begin
      SOFT_RESET <= full_single && opcode_reg == OP_SOFT_RESET
                    && permit_reg;
    end
  end

  // ---------------------------------------------------------------
  // status readout
  // ---------------------------------------------------------------
  logic [7:0] status1;
  logic [7:0] status2;
  logic [3:0] rd_idx_reg;

  always_comb begin
    status1                = '0;
    status1[LOCK_POS]      = lock_reg;
    status1[GUARD_PIN_POS] = pins_sync.guard_n;
    status1[PROTECT_POS]   = protect_reg;
    status1[WEL_POS]       = wel_reg;
    status1[BUSY_POS]      = OP_BUSY;
    status2                = '0;
    status2[PERMIT_POS]    = permit_reg;
    status2[BUSY_POS]      = OP_BUSY;
  end

  // index counts down through byte one then byte two, then repeats
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rd_idx_reg <= '1;
      SO         <= 1'b0;
      SO_OE      <= 1'b0;
    end else if (state_reg != ST_READ || cs_rise) begin
      rd_idx_reg <= '1;
      SO_OE      <= 1'b0;
    end else if (sck_fall) begin
      rd_idx_reg <= rd_idx_reg - 4'h1;
      SO_OE      <= 1'b1;
      SO         <= rd_idx_reg[3] ? status1[rd_idx_reg[2:0]]
                                  : status2[rd_idx_reg[2:0]];
    end
  end

  // ---------------------------------------------------------------
  // registered status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ARRAY_PROTECTED <= 1'b0;
      WRITE_LATCH     <= 1'b0;
      PROTECT_LOCK    <= 1'b0;
      RESET_PERMIT    <= 1'b0;
    end else begin
      ARRAY_PROTECTED <= protect_reg;
      WRITE_LATCH     <= wel_reg;
      PROTECT_LOCK    <= lock_reg;
      RESET_PERMIT    <= permit_reg;
    end
  end

endmodule : flash_status_regs
`default_nettype wire

// ### verification/flash_status_sva.sv
// assertion checker for the status register logic
`timescale 1ns/10ps
`default_nettype none
module flash_status_sva (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  input wire logic GUARD_N,
  input wire logic OP_BUSY,
  input wire logic SO,
  input wire logic SO_OE,
  input wire logic SOFT_RESET,
  input wire logic ARRAY_PROTECTED,
  input wire logic WRITE_LATCH,
  input wire logic PROTECT_LOCK,
  input wire logic RESET_PERMIT
);
  logic       cs_reg;
  logic [3:0] since_rise_reg;
  // cycles since chip select was last released
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cs_reg         <= 1'b1;
      since_rise_reg <= 4'hF;
    end else begin
      cs_reg <= CS_N;
      if (CS_N && !cs_reg)
        since_rise_reg <= 4'h0;
      else if (since_rise_reg != 4'hF)
        since_rise_reg <= since_rise_reg + 4'h1;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence s_latch_drop;
    ##[0:2] !WRITE_LATCH;
  endsequence
  sequence s_was_enabled;
    $past(WRITE_LATCH);
  endsequence
  property p_permit_latch;
    $changed(RESET_PERMIT) |-> s_was_enabled ##0 s_latch_drop;
  endproperty
  a_permit_latch: assert property (p_permit_latch)
    else $error("permit changed without write latch");
  property p_protect_latch;
    ($changed(PROTECT_LOCK) || $changed(ARRAY_PROTECTED))
      |-> s_was_enabled ##0 s_latch_drop;
  endproperty
  a_protect_latch: assert property (p_protect_latch)
    else $error("protect bits changed without write latch");
  property p_on_deselect;
    ($changed(PROTECT_LOCK) || $changed(ARRAY_PROTECTED)
     || $changed(RESET_PERMIT)) |-> since_rise_reg <= 4'hA;
  endproperty
  a_on_deselect: assert property (p_on_deselect)
    else $error("status bit changed away from deselect");
  property p_latch_clear;
    $fell(WRITE_LATCH) |-> since_rise_reg <= 4'hA;
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("write latch cleared away from deselect");
  property p_lock_guard;
    $fell(PROTECT_LOCK) |-> GUARD_N;
  endproperty
  a_lock_guard: assert property (p_lock_guard)
    else $error("lock cleared with guard asserted");
  property p_locked_protect;
    $changed(ARRAY_PROTECTED) |-> !($past(PROTECT_LOCK) && !GUARD_N);
  endproperty
  a_locked_protect: assert property (p_locked_protect)
    else $error("protect changed while locked");
  property p_reset_permit;
    SOFT_RESET |-> RESET_PERMIT ##1 !SOFT_RESET;
  endproperty
  a_reset_permit: assert property (p_reset_permit)
    else $error("soft reset without permit or too long");
  property p_permit_kept;
    SOFT_RESET |=> $stable(RESET_PERMIT)[*3];
  endproperty
  a_permit_kept: assert property (p_permit_kept)
    else $error("soft reset altered permit bit");
endmodule : flash_status_sva
bind flash_status_regs flash_status_sva chk_u (
  .CLOCK(CLOCK), .RST_N(RST_N), .SCK(SCK), .CS_N(CS_N), .SI(SI),
  .GUARD_N(GUARD_N), .OP_BUSY(OP_BUSY), .SO(SO), .SO_OE(SO_OE),
  .SOFT_RESET(SOFT_RESET), .ARRAY_PROTECTED(ARRAY_PROTECTED),
  .WRITE_LATCH(WRITE_LATCH), .PROTECT_LOCK(PROTECT_LOCK),
  .RESET_PERMIT(RESET_PERMIT));
`default_nettype wire

// ### verification/spi_host.sv
// host serial controller model driving the flash link
`timescale 1ns/10ps
`default_nettype none
module spi_host (
  input  wire logic CLOCK,
  output logic      SCK,
  output logic      CS_N,
  output logic      SI,
  input  wire logic SO,
  input  wire logic SO_OE
);
  initial begin
    SCK = 1'b0;
    CS_N = 1'b1;
    SI = 1'b0;
  end
  task automatic clk_wait(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : clk_wait
  // msb first, sck idles low between frames
  task automatic xfer(input logic [23:0] d, input int n,
                      output logic [15:0] rd);
    logic so_last;
    so_last = 1'b0;
    rd = 16'h0000;
    clk_wait(1);
    CS_N = 1'b0;
    for (int i = 0; i < n; i++) begin
      SI = d[n-1-i];
      clk_wait(4);
      SCK = 1'b1;
      clk_wait(4);
      so_last = SO_OE ? SO : ~so_last;
      if (i >= 8)
        rd = {rd[14:0], so_last};
      SCK = 1'b0;
    end
    clk_wait(4);
    CS_N = 1'b1;
    SI = ~SI;
    clk_wait(12);
  endtask : xfer
endmodule : spi_host
`default_nettype wire

// ### verification/tb_top.sv
// self-checking testbench for the status register logic
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import flash_status_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic guard_n = 1'b1;
  logic op_busy = 1'b0;
  logic sck, cs_n, si, so, so_oe, soft_reset;
  logic array_prot, wr_latch, prot_lock, permit;
  int   error_cnt = 0;
  int   checked = 0;
  int   pulses = 0;
  always #50 clock = ~clock;
  always @(posedge clock) if (soft_reset === 1'b1) pulses++;
  flash_status_regs dut_u (.CLOCK(clock), .RST_N(rst_n), .SCK(sck),
    .CS_N(cs_n), .SI(si), .GUARD_N(guard_n), .OP_BUSY(op_busy),
    .SO(so), .SO_OE(so_oe), .SOFT_RESET(soft_reset),
    .ARRAY_PROTECTED(array_prot), .WRITE_LATCH(wr_latch),
    .PROTECT_LOCK(prot_lock), .RESET_PERMIT(permit));
  spi_host host_u (.CLOCK(clock), .SCK(sck), .CS_N(cs_n), .SI(si),
    .SO(so), .SO_OE(so_oe));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // lock, protect, latch, permit
  task automatic chk_st(input logic [3:0] e);
    chk({12'h000, prot_lock, array_prot, wr_latch, permit}, {12'h000, e});
  endtask : chk_st
  task automatic send(input logic [23:0] d, input int n);
    logic [15:0] r;
    host_u.xfer(d, n, r);
  endtask : send
  task automatic rd_status(output logic [15:0] r);
    host_u.xfer({OP_READ_STATUS, 16'h0000}, 24, r);
  endtask : rd_status
  task automatic wren;
    send({16'h0000, OP_WRITE_ENABLE}, 8);
  endtask : wren
  task automatic t_power_up;
    logic [15:0] r;
    rd_status(r);
    chk(r, 16'h1000);
    chk_st(4'h0);
    op_busy = 1'b1;
    rd_status(r);
    chk({14'h0000, r[8], r[0]}, 16'h0003);
    wren;
    chk_st(4'h0);
    op_busy = 1'b0;
    rd_status(r);
    chk({14'h0000, r[8], r[0]}, 16'h0000);
    wren;
    chk_st(4'h2);
    send({16'h0000, OP_WRITE_DISABLE}, 8);
    chk_st(4'h0);
    $display("t_power_up done");
  endtask : t_power_up
  task automatic t_protect;
    logic [15:0] r;
    send({8'h00, OP_WRITE_STATUS, 8'h84}, 16);
    chk_st(4'h0);
    wren;
    chk_st(4'h2);
    send({OP_WRITE_STATUS, 8'h84, 8'h00}, 24);
    chk_st(4'hC);
    rd_status(r);
    chk(r, 16'h9400);
    wren;
    send({12'h000, OP_WRITE_STATUS, 4'h0}, 12);
    chk_st(4'hC);
    wren;
    send({7'h00, OP_WRITE_STATUS2, 8'h10, 1'b1}, 17);
    chk_st(4'hC);
    $display("t_protect done");
  endtask : t_protect
  task automatic t_guard;
    guard_n = 1'b0;
    wren;
    send({8'h00, OP_WRITE_STATUS, 8'h04}, 16);
    chk_st(4'hC);
    wren;
    send({8'h00, OP_WRITE_STATUS, 8'h80}, 16);
    chk_st(4'hC);
    guard_n = 1'b1;
    wren;
    send({8'h00, OP_WRITE_STATUS, 8'h00}, 16);
    chk_st(4'h0);
    $display("t_guard done");
  endtask : t_guard
  task automatic t_permit;
    logic [15:0] r;
    send({16'h0000, OP_SOFT_RESET}, 8);
    chk(16'(pulses), 16'h0000);
    wren;
    send({OP_WRITE_STATUS2, 8'hFF, 8'h00}, 24);
    chk_st(4'h1);
    rd_status(r);
    chk(r, 16'h1010);
    send({16'h0000, OP_SOFT_RESET}, 8);
    chk(16'(pulses), 16'h0001);
    chk_st(4'h1);
    wren;
    send({8'h00, OP_WRITE_STATUS, 8'h00}, 16);
    chk_st(4'h1);
    wren;
    send({OP_WRITE_STATUS2, 8'hEF, 8'hFF}, 24);
    chk_st(4'h0);
    $display("t_permit done");
  endtask : t_permit
  task automatic summarize;
    $display("checks=%0d errors=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    #2000000;
    error_cnt++;
    summarize;
  end
  initial begin
    repeat (20) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (8) @(posedge clock);
    t_power_up;
    t_protect;
    t_guard;
    t_permit;
    summarize;
  end
endmodule : tb_top
`default_nettype wire
